// ==== hw/sxu_subtract_unit.sv ====
// Subtract execute unit: literal and register minus accumulator
// Functional notes
// [RULE_01] Literal instruction: literal minus accumulator into accumulator, opcode 0000 1000.
// [RULE_02] Register instruction 0101 11da: file register minus accumulator, two's complement.
// [RULE_03] Destination bit clear: difference to accumulator, register untouched.
// [RULE_04] Destination bit set: difference written back to the file register.
// [RULE_05] Bank bit clear: address resolved inside the access bank.
// [RULE_06] Bank bit set: bank pointer joined with the 8-bit register field.
// [RULE_07] Bank clear with extended set: addresses up to 5Fh are indexed offsets.
// [RULE_08] One cycle each; negative, overflow, carry, nibble carry, zero updated. Code: operand staged, so acc, flags and done_r land two clocks after issue.
`timescale 1ns/1ps
`default_nettype none
`include "sxu_defines.svh"
module sxu_subtract_unit
  import sxu_pkg::*;
#(
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic ext_set_en,
  // Bank pointer and index base
  input wire logic [3:0] bank_pointer_reg,
  input wire logic [11:0] index_base,
  // Results
  output logic [7:0] acc_r,
  output sxu_flags_t flags_r,
  output logic done_r,
  output logic illegal_r,
  // Debug read of data memory
  input wire logic [AW-1:0] dbg_addr,
  output logic [7:0] dbg_data
);
  // ==========================================================
  // Decode
  function automatic logic is_lit(input logic [15:0] w);
    is_lit = (w[15:8] == `SXU_OP_LIT_HI);
  endfunction : is_lit
  function automatic logic is_reg(input logic [15:0] w);
    is_reg = (w[15:10] == `SXU_OP_REG_HI6);
  endfunction : is_reg

  // ==========================================================
  // Address resolution
  function automatic logic [11:0] resolve_addr(
    input logic [7:0] fa,
    input logic a_bit,
    input logic ext_en,
    input logic [3:0] bank,
    input logic [11:0] base
  );
    logic [11:0] indexed;
    indexed = base + {4'h0, fa};
    if (a_bit) begin
      return {bank, fa}; // RULE_06
    end
    if (ext_en && fa <= `SXU_ILO_LIMIT) begin
      return indexed; // RULE_07
    end
    if (fa < `SXU_ACCESS_SPLIT) begin
      return {4'h0, fa}; // RULE_05
    end
    return {`SXU_HIGH_ACCESS_BANK, fa}; // RULE_05
  endfunction : resolve_addr

  logic [11:0] eff_addr;
  always_comb begin
    eff_addr = resolve_addr(instr_word[7:0], instr_word[8], ext_set_en, bank_pointer_reg,
      index_base);
  end

  // ==========================================================
  // Operand fetch: file register read is registered, so stage one cycle
  logic [7:0] file_q;
  logic st_valid_r, st_valid_nxt;
  logic [15:0] st_word_r, st_word_nxt;
  logic [11:0] st_addr_r, st_addr_nxt;
  sxu_mem_wr_t wr;

  // ==========================================================
  // Data memory

  sxu_data_mem #(.AW(AW)) u_mem (
    .sys_clk(sys_clk),
    .rd_addr(instr_valid ? eff_addr[AW-1:0] : dbg_addr),
    .rd_data(file_q),
    .we(wr.we),
    .wr_addr(wr.addr[AW-1:0]),
    .wr_data(wr.data)
  );

  // ==========================================================
  // Debug read: shares the registered read port while nothing issues
  assign dbg_data = file_q;

  // ==========================================================
  // Operand stage registers
  // Issue held one cycle while the registered file read completes
  always_comb begin
    st_valid_nxt = instr_valid;
    st_word_nxt = instr_word;
    st_addr_nxt = eff_addr;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_valid_r <= 1'b0;
      st_word_r <= 16'h0000;
      st_addr_r <= 12'h000;
    end else begin
      st_valid_r <= st_valid_nxt;
      st_word_r <= st_word_nxt;
      st_addr_r <= st_addr_nxt;
    end
  end

  // ==========================================================
  // Staged decode
  logic st_lit;
  logic st_known;
  logic st_to_acc;
  assign st_lit = is_lit(st_word_r); // RULE_01
  assign st_known = st_lit || is_reg(st_word_r); // RULE_02
  assign st_to_acc = st_lit || !st_word_r[9]; // RULE_03

  // ==========================================================
  // Operand select
  logic [7:0] minuend;
  logic [7:0] subtrahend_n;
  always_comb begin
    minuend = st_lit ? st_word_r[7:0] : file_q; // RULE_01
    subtrahend_n = ~acc_r;
  end

  // ==========================================================
  // Ripple subtractor: minuend plus inverted accumulator plus one
  // Carry out of each bit is the no-borrow signal
  logic [8:0] carry_c;
  logic [7:0] diff;
  assign carry_c[0] = 1'b1;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
      assign diff[gi] = minuend[gi] ^ subtrahend_n[gi] ^ carry_c[gi]; // RULE_02
      assign carry_c[gi + 1] = (minuend[gi] & subtrahend_n[gi]) |
        (carry_c[gi] & (minuend[gi] ^ subtrahend_n[gi]));
    end
  endgenerate

  // ==========================================================
  // Result flags
  sxu_flags_t res_flags;
  always_comb begin
    res_flags.neg = diff[7]; // RULE_08
    res_flags.signed_overflow_flag = carry_c[8] ^ carry_c[7]; // RULE_08
    res_flags.zero = (diff == 8'h00); // RULE_08
    res_flags.nibble_carry_flag = carry_c[4]; // RULE_08
    res_flags.carry = carry_c[8]; // RULE_08
  end

  // ==========================================================
  // Accumulator and status
  logic [7:0] acc_nxt;
  sxu_flags_t flags_nxt;
  always_comb begin
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    if (st_valid_r && st_known) begin
      flags_nxt = res_flags; // RULE_08
      if (st_to_acc) begin
        acc_nxt = diff; // RULE_03
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= `SXU_ACC_RESET;
      flags_r <= `SXU_FLAG_RESET;
    end else begin
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================
  // File register write-back
  always_comb begin
    wr = '0;
    if (st_valid_r && st_known && !st_to_acc) begin
      wr.we = 1'b1; // RULE_04
      wr.addr = st_addr_r;
      wr.data = diff;
    end
  end

  // ==========================================================
  // Retire and refusal pulses
  logic done_nxt;
  logic illegal_nxt;
  always_comb begin
    done_nxt = st_valid_r && st_known; // RULE_08
    illegal_nxt = st_valid_r && !st_known; // RULE_02
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      done_r <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      illegal_r <= illegal_nxt;
    end
  end
endmodule : sxu_subtract_unit
`default_nettype wire

// ==== hw/sxu_defines.svh ====
// Constants for the subtract execute unit
`ifndef SXU_DEFINES_SVH
`define SXU_DEFINES_SVH
`define SXU_OP_LIT_HI 8'h08
`define SXU_OP_REG_HI6 6'h17
`define SXU_ILO_LIMIT 8'h5F
`define SXU_ACCESS_SPLIT 8'h60
`define SXU_HIGH_ACCESS_BANK 4'hF
`define SXU_ACC_RESET 8'h00
`define SXU_BANK_RESET 4'h0
`define SXU_FLAG_RESET 5'h00
`endif

// ==== hw/sxu_pkg.sv ====
// Types for the subtract execute unit
package sxu_pkg;
  typedef struct packed {
    logic neg;
    logic signed_overflow_flag;
    logic zero;
    logic nibble_carry_flag;
    logic carry;
  } sxu_flags_t;
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } sxu_mem_wr_t;
endpackage : sxu_pkg

// ==== hw/sxu_data_mem.sv ====
// Data memory for the subtract execute unit
`timescale 1ns/1ps
`default_nettype none
module sxu_data_mem #(
  parameter int AW = 12
) (
  // Clock
  input wire logic sys_clk,
  // Read port, registered
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data
);
  // Power-up contents cleared so first reads are defined
  logic [7:0] mem [0:(1<<AW)-1] = '{default: 8'h00};
  // ==========================================================
  // Storage
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : sxu_data_mem
`default_nettype wire

// ==== test/sxu_monitor.sv ====
// Checker for the subtract unit
`timescale 1ns/1ps
`default_nettype none
module sxu_monitor
  import sxu_pkg::*;
(
  // Clock, reset, issue
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  // Results
  input wire logic [7:0] acc_r,
  input wire sxu_flags_t flags_r,
  input wire logic done_r,
  input wire logic illegal_r
);
  // ====================
  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire lit = instr_valid && instr_word[15:8] == 8'h08;
  wire rg = instr_valid && instr_word[15:10] == 6'h17;
  lit_result_a: assert property (lit |-> ##2 done_r &&
    acc_r == $past(instr_word[7:0], 2) - $past(acc_r, 2)) else $error("literal result");
  lit_carry_a: assert property (lit |-> ##2
    flags_r.carry == ($past(instr_word[7:0], 2) >= $past(acc_r, 2)) &&
    flags_r.nibble_carry_flag == ($past(instr_word[3:0], 2) >= $past(acc_r[3:0], 2)))
    else $error("carry flags");
  lit_ovf_a: assert property (lit |-> ##2 flags_r.signed_overflow_flag ==
    ($past(instr_word[7], 2) != $past(acc_r[7], 2) && acc_r[7] != $past(instr_word[7], 2)))
    else $error("overflow flag");
  lit_nz_a: assert property (lit |-> ##2
    flags_r.zero == (acc_r == 8'h00) && flags_r.neg == acc_r[7]) else $error("zero flag");
  reg_keep_a: assert property (rg && instr_word[9] |-> ##2
    done_r && acc_r == $past(acc_r, 2)) else $error("acc changed");
  reg_nz_a: assert property (rg && !instr_word[9] |-> ##2 done_r &&
    flags_r.zero == (acc_r == 8'h00) && flags_r.neg == acc_r[7]) else $error("reg flags");
  bad_op_a: assert property (instr_valid && !lit && !rg |-> ##2 illegal_r &&
    !done_r && acc_r == $past(acc_r, 2)) else $error("bad opcode");
  idle_quiet_a: assert property (!instr_valid |-> ##2
    !done_r && !illegal_r) else $error("spurious pulse");
endmodule : sxu_monitor
bind sxu_subtract_unit sxu_monitor u_mon (.sys_clk, .reset_n, .instr_valid, .instr_word,
  .acc_r, .flags_r, .done_r, .illegal_r);
`default_nettype wire

// ==== test/sxu_subtract_unit_tb_top.sv ====
// Testbench for the subtract unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module sxu_subtract_unit_tb_top
  import sxu_pkg::*;
;
  logic sys_clk = 0, reset_n = 0, instr_valid = 0, ext_set_en = 0, done_r, illegal_r;
  logic [15:0] instr_word = 16'h0000, lf = 16'h6685;
  logic [3:0] bank_pointer_reg = 4'h0;
  logic [11:0] index_base = 12'h000, dbg_addr = 12'h000, ad;
  logic [7:0] acc_r, dbg_data, acc, m, k, f, d8;
  sxu_flags_t flags_r, fx;
  logic [7:0] mdl [0:4095] = '{default: 8'h00};
  int err_count = 0, comparisons = 0;
  sxu_subtract_unit u_dut (.sys_clk, .reset_n, .instr_valid, .instr_word, .ext_set_en,
    .bank_pointer_reg, .index_base, .acc_r, .flags_r, .done_r, .illegal_r, .dbg_addr,
    .dbg_data);
  initial forever #25 sys_clk = ~sys_clk;
  // ====================
  // Helpers
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  function automatic sxu_flags_t flg(input logic [7:0] a, input logic [7:0] w);
    sxu_flags_t o;
    logic [7:0] r;
    r = a - w;
    o.neg = r[7];
    o.signed_overflow_flag = (a[7] != w[7]) && (r[7] != a[7]);
    o.zero = (r == 8'h00);
    o.nibble_carry_flag = (a[3:0] >= w[3:0]);
    o.carry = (a >= w);
    return o;
  endfunction : flg
  function automatic logic [11:0] ea(input logic [7:0] fa, input logic a);
    if (a) return {bank_pointer_reg, fa};
    if (ext_set_en && fa <= 8'h5F) return index_base + {4'h0, fa};
    return {(fa < 8'h60) ? 4'h0 : 4'hF, fa};
  endfunction : ea
  task automatic issue(input logic [15:0] w);
    @(negedge sys_clk) instr_valid = 1'b1;
    instr_word = w;
    @(negedge sys_clk) instr_valid = 1'b0;
    @(negedge sys_clk);
  endtask : issue
  task automatic rd(input logic [11:0] a);
    @(negedge sys_clk) dbg_addr = a;
    @(negedge sys_clk) d8 = dbg_data;
  endtask : rd
  task automatic lit(input logic [7:0] kk);
    fx = flg(kk, acc);
    acc = kk - acc;
    issue({8'h08, kk});
    `CHK(acc_r, acc)
    `CHK(flags_r, fx)
    `CHK(done_r, 1'b1)
  endtask : lit
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // ====================
  // Tests
  initial begin
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    acc = 8'h00;
    for (int i = 0; i < 24; i++) begin
      lf = nx(lf);
      lit((i < 3) ? 8'h02 + i[7:0] : lf[7:0]);
    end
    $display("literal test done");
    issue(16'hFFFF);
    `CHK(illegal_r, 1'b1)
    `CHK(acc_r, acc)
    `CHK(done_r, 1'b0)
    $display("opcode test done");
    for (int i = 0; i < 16; i++) begin
      lf = nx(lf);
      @(negedge sys_clk) reset_n = 1'b0;
      @(negedge sys_clk) reset_n = 1'b1;
      acc = 8'h00;
      ext_set_en = lf[10] | (i < 2);
      bank_pointer_reg = lf[15:12];
      index_base = {lf[3:0], lf[15:8]};
      f = (i < 2) ? 8'h5F + i[7:0] : lf[7:0];
      lit(lf[11:4]);
      ad = ea(f, lf[9] & (i > 1));
      m = mdl[ad];
      rd(ad);
      `CHK(d8, m)
      k = m - acc;
      fx = flg(m, acc);
      issue({6'h17, lf[8], lf[9] & (i > 1), f});
      if (!lf[8]) acc = k;
      else mdl[ad] = k;
      `CHK(acc_r, acc)
      `CHK(flags_r, fx)
      rd(ad);
      `CHK(d8, mdl[ad])
    end
    $display("register test done");
    finish_test();
  end
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule : sxu_subtract_unit_tb_top
`default_nettype wire
